/* timer_core.sv */
// Reloadable 16-bit timer with one-shot, continuous, PWM, dual PWM and capture modes on APB.
`timescale 1ns/1ns
module timer_core
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer pins.
   input wire logic timer_in,
   output logic timer_out,
   output logic timer_out_oe,
   output logic timer_out_comp,
   output logic timer_out_comp_oe,
   // Event.
   output logic timer_irq
);
   typedef struct packed
   {
      logic [ctl_width-1:0] ctl;
      logic [15:0] count;
      logic [15:0] reload;
      logic [15:0] pwm;
      logic [7:0] deadband;
      logic [7:0] db_cnt;
      logic out_raw;
      logic out;
      logic out_comp;
      logic reload_seen;
      logic capture_seen;
      logic irq;
      logic [31:0] rdata;
   } state_s;
   state_s state;
   state_s next_state;

   logic enable;
   logic polarity;
   logic out_en;
   mode_e mode;
   logic tick;
   logic in_level;
   logic in_rise;
   logic in_fall;
   logic access;
   logic wr;
   logic hit;
   logic at_reload;
   logic pwm_level;

   assign enable = state.ctl[ctl_enable];
   assign polarity = state.ctl[ctl_polarity];
   assign out_en = state.ctl[ctl_outen];
   assign mode = mode_e'(state.ctl[ctl_mode_lo +: ctl_mode_w]);
   assign access = psel && penable;
   assign wr = access && pwrite;

   // ===========================================================================
   // Prescaled system clock is the only count source.
   timer_prescaler u_presc
   (
      .pclk(pclk),
      .presetn(presetn),
      .run(enable),
      .presc_sel(state.ctl[ctl_presc_lo +: ctl_presc_w]),
      .tick(tick) // RQ5
   );

   timer_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .pin(timer_in),
      .level(in_level),
      .rise(in_rise),
      .fall(in_fall)
   );

   // ===========================================================================
   // Shared pin: complementary output only in dual PWM mode.
   assign timer_out_comp_oe = (mode == mode_dual_pwm); // RQ12 RQ17
   assign timer_out_oe = out_en;
   assign timer_out = state.out;
   assign timer_out_comp = state.out_comp;
   assign timer_irq = state.irq;
   assign prdata = state.rdata;
   assign pready = 1'b1;

   // ===========================================================================
   // Timer and register logic.
   always_comb
   begin
      next_state = state;
      next_state.irq = 1'b0;
      at_reload = (state.count == state.reload);
      // Compare level for PWM: polarity level up to compare, its inverse above it up to reload.
      pwm_level = (state.count > state.pwm) ? !polarity : polarity; // RQ13 RQ14
      hit = 1'b1;
      next_state.rdata = zero_word;
      pslverr = 1'b0;

      if (enable && tick)
      begin
         case (mode)
            mode_continuous, mode_one_shot:
            begin
               if (at_reload) // RQ1
               begin
                  next_state.irq = 1'b1; // RQ2
                  next_state.count = count_restart; // RQ2 RQ4 RQ6
                  next_state.reload_seen = 1'b1;
                  if (mode == mode_one_shot)
                  begin
                     next_state.ctl[ctl_enable] = 1'b0;
                  end
                  else
                  begin
                     next_state.out_raw = !state.out_raw; // RQ3
                  end
               end
               else
               begin
                  next_state.count = state.count + 16'h0001; // RQ19
               end
            end
            mode_pwm, mode_dual_pwm:
            begin
               if (at_reload)
               begin
                  next_state.irq = 1'b1;
                  next_state.count = count_restart; // RQ9 RQ6
                  next_state.reload_seen = 1'b1;
               end
               else
               begin
                  next_state.count = state.count + 16'h0001; // RQ19
               end
            end
            default:
            begin
               next_state.count = state.count + 16'h0001; // RQ15 RQ19
               if (at_reload)
               begin
                  next_state.count = count_restart;
                  next_state.irq = 1'b1;
               end
            end
         endcase
      end

      // Capture on the edge that the polarity bit selects.
      if (enable && (mode == mode_capture) && (polarity ? in_fall : in_rise)) // RQ16
      begin
         next_state.pwm = state.count; // RQ15
         next_state.capture_seen = 1'b1;
         next_state.irq = 1'b1;
      end

      // Outputs per mode.
      if (!enable)
      begin
         next_state.out = state.out_raw; // RQ7
         next_state.out_comp = !state.out_raw;
         next_state.db_cnt = state.deadband;
      end
      else if (mode == mode_pwm)
      begin
         next_state.out = pwm_level; // RQ13 RQ14
      end
      else if (mode == mode_dual_pwm)
      begin
         if (pwm_level != state.out_raw)
         begin
            next_state.out_raw = pwm_level;
            next_state.db_cnt = state.deadband;
            // Both outputs go low; without a dead band the new level follows at once.
            next_state.out = (state.deadband == 8'h00) && pwm_level; // RQ18
            next_state.out_comp = (state.deadband == 8'h00) && !pwm_level; // RQ18
         end
         else if (state.db_cnt != 8'h00)
         begin
            if (tick)
            begin
               next_state.db_cnt = state.db_cnt - 8'h01;
               if (state.db_cnt == 8'h01)
               begin
                  next_state.out = state.out_raw; // RQ18
                  next_state.out_comp = !state.out_raw;
               end
            end
         end
         else
         begin
            next_state.out = state.out_raw; // RQ18
            next_state.out_comp = !state.out_raw;
         end
      end
      else
      begin
         next_state.out = state.out_raw; // RQ3
      end

      // APB register access, single-cycle answer.
      if (access)
      begin
         if (paddr == off_control)
         begin
            next_state.rdata = 32'(state.ctl);
            if (wr)
            begin
               next_state.ctl = pwdata[ctl_width-1:0];
               // A write that leaves or finds the timer stopped sets the idle output level.
               if (!state.ctl[ctl_enable] || !pwdata[ctl_enable])
               begin
                  next_state.out_raw = pwdata[ctl_polarity]; // RQ7
               end
            end
         end
         else if (paddr == off_count)
         begin
            next_state.rdata = 32'(state.count);
            if (wr)
            begin
               next_state.count = pwdata[15:0]; // RQ4 RQ9
            end
         end
         else if (paddr == off_reload)
         begin
            next_state.rdata = 32'(state.reload);
            if (wr)
            begin
               next_state.reload = pwdata[15:0];
            end
         end
         else if (paddr == off_pwm)
         begin
            next_state.rdata = 32'(state.pwm);
            if (wr)
            begin
               next_state.pwm = pwdata[15:0];
            end
         end
         else if (paddr == off_deadband)
         begin
            next_state.rdata = 32'(state.deadband);
            if (wr)
            begin
               next_state.deadband = pwdata[7:0];
            end
         end
         else if (paddr == off_status)
         begin
            next_state.rdata = 32'({in_level, state.capture_seen, state.reload_seen});
            if (wr)
            begin
               // Write one to clear; a new event in the same cycle wins unless its flag was already set.
               if (pwdata[0] && !(next_state.reload_seen && !state.reload_seen))
               begin
                  next_state.reload_seen = 1'b0;
               end
               if (pwdata[1] && !(next_state.capture_seen && !state.capture_seen))
               begin
                  next_state.capture_seen = 1'b0;
               end
            end
         end
         else
         begin
            hit = 1'b0;
         end
         pslverr = !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state.ctl <= '0;
         state.count <= count_reset;
         state.reload <= reload_reset;
         state.pwm <= pwm_reset;
         state.deadband <= deadband_reset;
         state.db_cnt <= 8'h00;
         state.out_raw <= 1'b0;
         state.out <= 1'b0;
         state.out_comp <= 1'b1;
         state.reload_seen <= 1'b0;
         state.capture_seen <= 1'b0;
         state.irq <= 1'b0;
         state.rdata <= zero_word;
      end
      else
      begin
         state <= next_state;
      end
   end
endmodule

/* timer_pkg.sv */
// Package with register map, field layout and constants of the reloadable timer.
//
// What this block does
// [RQ1] Continuous mode counts upward until count equals the 16-bit reload value.
// [RQ2] At reload in continuous mode raise interrupt, load 0001H, keep counting.
// [RQ3] Continuous mode with output enabled inverts the output at every reload.
// [RQ4] Written start count applies to first continuous pass only; later passes start 0001H.
// [RQ5] One-shot and continuous modes count prescaled system clock, never the input pin.
// [RQ6] First period is (reload minus start plus one) times prescale; later periods reload times prescale.
// [RQ7] Before counting, the output takes the initial level software programmed.
// [RQ8] Software disables the timer while configuring and enables it last.
// [RQ9] PWM start count affects only the first pass; afterwards counting resumes at 0001H.
// [RQ10] Software keeps dead band shorter than both PWM phases.
// [RQ11] Software keeps reload strictly greater than the PWM compare value.
// [RQ12] Dual PWM mode switches the shared pin from timer input to complementary output.
// [RQ13] Polarity bit 0: output high for reload minus PWM value counts per period.
// [RQ14] Polarity bit 1: output high for PWM value counts per period.
// [RQ15] Capture mode counts system clock and copies count to PWM registers on edge.
// [RQ16] In capture mode the polarity bit selects rising or falling capture edge.
// [RQ17] One pin carries timer input and complementary output; mode alone selects function.
// [RQ18] Dual PWM inserts dead band, in prescaled clocks, before each rising output edge.
// [RQ19] Count increments by one per prescaler tick while enabled and holds while disabled.
package timer_pkg;
   // ===========================================================================
   // Register offsets (byte addresses on APB).
   localparam logic [11:0] off_control = 12'h000;
   localparam logic [11:0] off_count = 12'h004;
   localparam logic [11:0] off_reload = 12'h008;
   localparam logic [11:0] off_pwm = 12'h00c;
   localparam logic [11:0] off_deadband = 12'h010;
   localparam logic [11:0] off_status = 12'h014;
   // ===========================================================================
   // Control register fields.
   localparam int ctl_enable = 7;
   localparam int ctl_polarity = 6;
   localparam int ctl_presc_lo = 3;
   localparam int ctl_presc_w = 3;
   localparam int ctl_mode_lo = 0;
   localparam int ctl_mode_w = 3;
   localparam int ctl_outen = 8;
   localparam int ctl_width = 9;
   // ===========================================================================
   // Modes and reset values.
   typedef enum logic [2:0]
   {
      mode_one_shot = 3'h0,
      mode_continuous = 3'h1,
      mode_pwm = 3'h2,
      mode_capture = 3'h3,
      mode_dual_pwm = 3'h4
   } mode_e;
   localparam logic [15:0] count_restart = 16'h0001;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [15:0] reload_reset = 16'hffff;
   localparam logic [15:0] pwm_reset = 16'h0000;
   localparam logic [7:0] deadband_reset = 8'h00;
   localparam logic [31:0] zero_word = 32'h0000_0000;
   localparam int presc_width = 7;
endpackage

/* timer_prescaler.sv */
// Prescaler that divides the system clock by a power of two.
`timescale 1ns/1ns
module timer_prescaler
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic run,
   input wire logic [ctl_presc_w-1:0] presc_sel,
   // Tick.
   output logic tick
);
   typedef struct packed
   {
      logic [presc_width-1:0] div;
   } state_s;
   state_s state;
   state_s next_state;
   logic [presc_width-1:0] mask;

   // ===========================================================================
   // Divider: a tick every 2**presc_sel clocks.
   always_comb
   begin
      next_state = state;
      mask = presc_width'((8'h01 << presc_sel) - 8'h01);
      tick = run && ((state.div & mask) == mask);
      if (!run)
      begin
         next_state.div = '0;
      end
      else
      begin
         next_state.div = presc_width'(state.div + 1'b1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end
endmodule

/* timer_sync.sv */
// Three-stage synchroniser with agreement check for the timer input pin.
`timescale 1ns/1ns
module timer_sync
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Pin and result.
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed
   {
      logic [2:0] sr;
      logic level;
   } state_s;
   state_s state;
   state_s next_state;

   // ===========================================================================
   // A new level counts once stages two and three agree.
   always_comb
   begin
      next_state = state;
      next_state.sr = {state.sr[1:0], pin};
      if (state.sr[1] == state.sr[2])
      begin
         next_state.level = state.sr[2];
      end
      level = state.level;
      rise = next_state.level && !state.level;
      fall = !next_state.level && state.level;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end
endmodule

/* timer_chk.sv */
// Port checks for the reloadable timer.
`timescale 1ns/1ns
module timer_chk
   import timer_pkg::*;
(
   // Bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Pins.
   input wire logic timer_out,
   input wire logic timer_out_oe,
   input wire logic timer_out_comp,
   input wire logic timer_out_comp_oe,
   input wire logic timer_irq
);
   // ==========================================================================
   // Shadow of the written setup and run-length counters.
   logic [8:0] ctl;
   logic [15:0] rld;
   logic [15:0] pwm;
   logic [31:0] age;
   logic [31:0] gap;
   logic [31:0] run;
   logic gap_ok;
   logic run_ok;
   logic wr;
   logic [31:0] presc;
   assign wr = psel && penable && pwrite && pready;
   assign presc = 32'h1 << ctl[5:3];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl <= 9'h0;
         rld <= reload_reset;
         pwm <= pwm_reset;
         age <= 32'h0;
         gap <= 32'h0;
         run <= 32'h0;
         gap_ok <= 1'b0;
         run_ok <= 1'b0;
      end
      else
      begin
         age <= wr ? 32'h0 : age + 32'h1;
         if (wr && paddr == off_control)
            ctl <= pwdata[8:0];
         if (wr && paddr == off_reload)
            rld <= pwdata[15:0];
         if (wr && paddr == off_pwm)
            pwm <= pwdata[15:0];
         gap <= timer_irq ? 32'h1 : gap + 32'h1;
         gap_ok <= !wr && (timer_irq || gap_ok);
         run <= $rose(timer_out) ? 32'h1 : run + 32'h1;
         run_ok <= !wr && ($rose(timer_out) || run_ok);
      end
   end
   // ==========================================================================
   // Properties.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_reload;
      timer_irq && ctl[7] && ctl[8] && ctl[2:0] == mode_continuous && age > 32'h2;
   endsequence
   property p_toggle;
      s_reload |-> ##[0:1] $changed(timer_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle at reload");
   property p_gap;
      timer_irq && gap_ok && ctl[7] && ctl[2:0] == mode_continuous |-> gap == presc * {16'h0, rld};
   endproperty
   a_gap: assert property (p_gap) else $error("reload spacing wrong");
   property p_high;
      $fell(timer_out) && run_ok && ctl[7] && ctl[2:0] == mode_pwm
         |-> run == presc * (ctl[6] ? {16'h0, pwm} : {16'h0, rld - pwm});
   endproperty
   a_high: assert property (p_high) else $error("pwm high time wrong");
   property p_oe;
      age > 32'h1 |-> timer_out_oe == ctl[8];
   endproperty
   a_oe: assert property (p_oe) else $error("output enable wrong");
   property p_comp_oe;
      age > 32'h1 |-> timer_out_comp_oe == (ctl[2:0] == mode_dual_pwm);
   endproperty
   a_comp_oe: assert property (p_comp_oe) else $error("pin function wrong");
   property p_gapband;
      ctl[7] && ctl[2:0] == mode_dual_pwm && age > 32'h3 |-> !(timer_out && timer_out_comp);
   endproperty
   a_gapband: assert property (p_gapband) else $error("outputs overlap");
   property p_idle;
      !ctl[7] && age > 32'h1 |-> !timer_irq;
   endproperty
   a_idle: assert property (p_idle) else $error("event while stopped");
   property p_level;
      !ctl[7] && age > 32'h1 |-> timer_out == ctl[6];
   endproperty
   a_level: assert property (p_level) else $error("initial level wrong");
endmodule

/* timer_src.sv */
// Far-side model: drives the shared timer pin.
`timescale 1ns/1ns
module timer_src
(
   // Clock.
   input wire logic pclk,
   // Shared pin.
   input wire logic timer_out_comp,
   input wire logic timer_out_comp_oe,
   output logic timer_in
);
   logic lvl = 1'b0;
   logic spin = 1'b0;
   always @(posedge pclk)
      if (spin)
         lvl <= !lvl;
   // The pin carries the device's complement while it drives it.
   assign timer_in = timer_out_comp_oe ? timer_out_comp : lvl;
   task automatic set_level(input logic v);
      @(posedge pclk);
      lvl <= v;
   endtask
   task automatic set_spin(input logic v);
      @(posedge pclk);
      spin <= v;
   endtask
endmodule

/* test_timer_core.sv */
// Self-checking bench for the reloadable timer.
`timescale 1ns/1ns
module test_timer_core
   import timer_pkg::*;
();
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, timer_in, timer_out, timer_out_oe, timer_out_comp, timer_out_comp_oe, timer_irq;
   logic [31:0] q, c;
   logic [31:0] hit [2];
   logic e;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_irq = 0;
   time t_acc, t_rise, ta, fa, fb, pa, pb;
   timer_core timer_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .timer_in, .timer_out, .timer_out_oe, .timer_out_comp, .timer_out_comp_oe, .timer_irq);
   timer_src timer_src_i (.pclk, .timer_out_comp, .timer_out_comp_oe, .timer_in);
   always #5 pclk = !pclk;
   always @(posedge timer_out)
      t_rise = $time;
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (timer_irq === 1'b1)
         n_irq <= n_irq + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         results;
      end
   end
   // ==========================================================================
   // Tasks.
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      e = pslverr;
      t_acc = $time;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      q = prdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic wait_irq(output time t);
      int n0;
      n0 = n_irq;
      for (int i = 0; i < 2000 && n_irq == n0; i++)
         @(posedge pclk);
      if (n_irq == n0)
         n_fail++;
      t = $time;
   endtask
   function automatic logic [31:0] ctlw(input mode_e m, input logic [2:0] ps, input logic pol, input logic en);
      return {23'h0, 1'b1, en, pol, ps, m};
   endfunction
   task automatic cont(input logic [31:0] s, output time f, output time p);
      time t1, t2, t3;
      wr(off_control, ctlw(mode_continuous, 3'h1, 1'b0, 1'b0));
      wr(off_count, s);
      wr(off_reload, 32'h8);
      wr(off_control, ctlw(mode_continuous, 3'h1, 1'b0, 1'b1));
      f = t_acc;
      wait_irq(t1);
      wait_irq(t2);
      wait_irq(t3);
      f = t1 - f;
      p = t3 - t2;
   endtask
   // ==========================================================================
   // Tests.
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, off_reload, 32'h0);
      check(q, 32'hffff);
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, e}, 32'h1);
      for (int v = 0; v < 2; v++)
      begin
         wr(off_control, ctlw(mode_continuous, 3'h0, v[0], 1'b0));
         repeat (3) @(posedge pclk);
         check({31'h0, timer_out}, 32'(v));
      end
      $display("initial level done");
      cont(32'h1, fa, pa);
      cont(32'h5, fb, pb);
      check(32'((fa - fb) / 10), 32'h8);
      check(32'(pa / 10), 32'h10);
      $display("continuous done");
      wr(off_control, ctlw(mode_continuous, 3'h0, 1'b0, 1'b0));
      wr(off_reload, 32'hffff);
      wr(off_control, ctlw(mode_continuous, 3'h0, 1'b0, 1'b1));
      timer_src_i.set_spin(1'b1);
      apb(1'b0, off_count, 32'h0);
      c = q;
      ta = t_acc;
      repeat (20) @(posedge pclk);
      apb(1'b0, off_count, 32'h0);
      check(q - c, 32'((t_acc - ta) / 10));
      wr(off_control, ctlw(mode_continuous, 3'h0, 1'b0, 1'b0));
      apb(1'b0, off_count, 32'h0);
      c = q;
      repeat (20) @(posedge pclk);
      apb(1'b0, off_count, 32'h0);
      check(q, c);
      timer_src_i.set_spin(1'b0);
      $display("counting done");
      wr(off_control, ctlw(mode_one_shot, 3'h0, 1'b0, 1'b0));
      wr(off_count, 32'h1);
      wr(off_reload, 32'h4);
      wr(off_control, ctlw(mode_one_shot, 3'h0, 1'b0, 1'b1));
      wait_irq(ta);
      repeat (20) @(posedge pclk);
      apb(1'b0, off_control, 32'h0);
      check(q, ctlw(mode_one_shot, 3'h0, 1'b0, 1'b0));
      $display("one-shot done");
      for (int v = 0; v < 2; v++)
      begin
         wr(off_control, ctlw(mode_pwm, 3'h0, v[0], 1'b0));
         wr(off_count, 32'h1);
         wr(off_pwm, 32'h4);
         wr(off_reload, 32'ha);
         wr(off_control, ctlw(mode_pwm, 3'h0, v[0], 1'b1));
         repeat (3) @(negedge timer_out);
         check(32'(($time - t_rise) / 10), v ? 32'h4 : 32'h6);
      end
      $display("pwm done");
      wr(off_control, ctlw(mode_dual_pwm, 3'h0, 1'b0, 1'b0));
      wr(off_deadband, 32'h2);
      wr(off_pwm, 32'h5);
      wr(off_reload, 32'hc);
      wr(off_control, ctlw(mode_dual_pwm, 3'h0, 1'b0, 1'b1));
      check({31'h0, timer_out_comp_oe}, 32'h1);
      repeat (2) @(negedge timer_out_comp);
      ta = $time;
      @(posedge timer_out);
      check(32'(($time - ta) / 10), 32'h2);
      $display("dual pwm done");
      for (int v = 0; v < 2; v++)
      begin
         wr(off_control, ctlw(mode_capture, 3'h0, v[0], 1'b0));
         wr(off_reload, 32'hffff);
         timer_src_i.set_level(1'b0);
         repeat (8) @(posedge pclk);
         wr(off_control, ctlw(mode_capture, 3'h0, v[0], 1'b1));
         c = n_irq;
         timer_src_i.set_level(1'b1);
         repeat (12) @(posedge pclk);
         hit[v] = n_irq - c;
         timer_src_i.set_level(1'b0);
         repeat (12) @(posedge pclk);
         check(n_irq - c, 32'h1);
      end
      check({31'h0, hit[0] != hit[1]}, 32'h1);
      $display("capture done");
      results;
   end
endmodule
bind timer_core timer_chk timer_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .timer_out, .timer_out_oe, .timer_out_comp, .timer_out_comp_oe, .timer_irq);
